/* File: rtl/arm_seq_regs.vh */
// Purpose: register offsets, field positions, reset values and limits
// Assumes: AXI4-Lite slave with 32-bit data, byte addresses
// Notes: offsets below are byte addresses of aligned words
`ifndef ARM_SEQ_REGS_VH
`define ARM_SEQ_REGS_VH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define OFS_CTRL        5'h00
`define OFS_MODE        5'h04
`define OFS_BURST       5'h08
`define OFS_POINTS      5'h0C
`define OFS_DELAY       5'h10
`define OFS_LEVELS      5'h14
`define OFS_STATUS      5'h18
`define OFS_COUNTS      5'h1C

// ------------------------------------------------------------------
// control register fields (write pulses)
// ------------------------------------------------------------------
`define CTRL_BEGIN      0
`define CTRL_ABORT      1
`define CTRL_ARM_NOW    2

// ------------------------------------------------------------------
// mode register fields
// ------------------------------------------------------------------
`define MODE_SRC_A_LO   0
`define MODE_SRC_B_LO   2
`define MODE_EDGE_A     4
`define MODE_EDGE_B     5
`define MODE_PREARM     6
`define MODE_INF        7
`define MODE_WIN_ENTER  8

// arm source selections, 2 bits each
`define SRC_HOLD        2'h0
`define SRC_EXT         2'h1
`define SRC_LEVEL       2'h2
`define SRC_WINDOW      2'h3

// ------------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------------
`define RST_BURST       16'h0001
`define RST_POINTS      20'h00001
`define RST_DELAY       20'h00000
`define MAX_PREARM_BURST 16'h0080
`define MEM_ADDR_W      19

`endif

/* File: rtl/arm_edge_detect.v */
// Purpose: one arm source: synchronise, qualify by edge, level or window
// Assumes: ext pin asynchronous; sample words already on clk_sys
// Notes: emits a one-cycle event pulse
`timescale 1ns/1ps
`include "arm_seq_regs.vh"

module arm_edge_detect (
    input  wire        clk_sys,
    input  wire        arst_n,
    input  wire [1:0]  source_sel,
    input  wire        edge_falling,
    input  wire        window_enter,
    input  wire        ext_pin,
    input  wire [15:0] sample,
    input  wire [15:0] window_upper_level,
    input  wire [15:0] window_lower_level,
    output reg         arm_event
);

    reg  ext_meta;
    reg  ext_sync;
    reg  qual_prev;
    reg  qual_now;

    // two flops for the pin before anyone looks at it
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
        end else begin
            ext_meta <= ext_pin;
            ext_sync <= ext_meta;
        end
    end

    // qualified level for the chosen source; window compares signed samples
    always @* begin
        case (source_sel)
            `SRC_EXT:    qual_now = ext_sync;
            `SRC_LEVEL:  qual_now = ($signed(sample) >= $signed(window_upper_level));
            `SRC_WINDOW: qual_now = window_enter ^
                         (($signed(sample) > $signed(window_upper_level)) ||
                          ($signed(sample) < $signed(window_lower_level)));
            default:     qual_now = 1'b0; // hold gives no events
        endcase
    end

    // the selected edge of the qualified level is the event
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            qual_prev <= 1'b0;
            arm_event <= 1'b0;
        end else begin
            qual_prev <= qual_now;
            arm_event <= edge_falling ? (qual_prev & ~qual_now)
                                      : (~qual_prev & qual_now);
        end
    end

endmodule // arm_edge_detect

/* File: rtl/arm_trigger_sequencer.v */
// Purpose: four-state acquisition sequencer with arm/trigger counting
// Assumes: AXI4-Lite master keeps one read and one write in flight
// Notes: memory write addresses are produced here, storage is outside
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "arm_seq_regs.vh"

module arm_trigger_sequencer (
    input  wire        clk_sys,
    input  wire        arst_n,
    // axi4-lite slave
    input  wire [4:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [4:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // events and samples
    input  wire        ext_arm_a,
    input  wire        ext_arm_b,
    input  wire        trigger_in,
    input  wire [15:0] sample_a,
    input  wire [15:0] sample_b,
    // acquisition outputs
    output reg         sampling,
    output reg         take_reading,
    output reg  [18:0] mem_addr,
    output reg         transfer_abort,
    output reg         pending_op
);

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_INIT = 4'h2;
    localparam [3:0] ST_WARM = 4'h4;
    localparam [3:0] ST_WTRG = 4'h8;

    reg  [3:0]  state;
    reg  [3:0]  next_state;

    // configuration
    reg  [1:0]  src_a;
    reg  [1:0]  src_b;
    reg         edge_a;
    reg         edge_b;
    reg         prearm;
    reg         burst_inf;
    reg         win_enter;
    reg  [15:0] burst_total;
    reg  [19:0] sweep_point_total;
    reg  [19:0] arm_delay;
    reg  [15:0] window_upper_level;
    reg  [15:0] window_lower_level;

    // run state
    reg  [15:0] bursts_done;
    reg  [19:0] readings;
    reg  [19:0] delay_cnt;
    reg         delaying;
    reg         wrapped;
    reg  [18:0] part_base;
    reg         cmd_begin;
    reg         cmd_abort;
    reg         cmd_arm_now;
    reg         trig_meta;
    reg         trig_sync;
    reg         trig_prev;

    wire        arm_ev_a;
    wire        arm_ev_b;
    wire        arm_any;
    wire        trig_ev;
    wire        wr_go;
    wire        rd_go;
    wire        burst_met;
    wire        last_reading;
    wire [15:0] burst_eff;

    // ------------------------------------------------------------------
    // arm sources
    // ------------------------------------------------------------------
    arm_edge_detect u_arm_a (
        .clk_sys            (clk_sys),
        .arst_n             (arst_n),
        .source_sel         (src_a),
        .edge_falling       (edge_a),
        .window_enter       (win_enter),
        .ext_pin            (ext_arm_a),
        .sample             (sample_a),
        .window_upper_level (window_upper_level),
        .window_lower_level (window_lower_level),
        .arm_event          (arm_ev_a)
    );

    arm_edge_detect u_arm_b (
        .clk_sys            (clk_sys),
        .arst_n             (arst_n),
        .source_sel         (src_b),
        .edge_falling       (edge_b),
        .window_enter       (win_enter),
        .ext_pin            (ext_arm_b),
        .sample             (sample_b),
        .window_upper_level (window_upper_level),
        .window_lower_level (window_lower_level),
        .arm_event          (arm_ev_b)
    );

    assign arm_any = arm_ev_a | arm_ev_b | cmd_arm_now;

    // trigger pin: two flops then rising-edge detect
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
        end else begin
            trig_meta <= trigger_in;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end
    assign trig_ev = trig_sync & ~trig_prev;

    // ------------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------------
    // both address and data must be present; one write at a time
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid &
                   ~s_axi_awready;
    assign rd_go = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;

    // pre-arm runs clamp the burst count at 128
    assign burst_eff = (prearm && burst_total > `MAX_PREARM_BURST) ?
                       `MAX_PREARM_BURST : burst_total;
    assign burst_met = ~burst_inf && (bursts_done >= burst_eff);
    assign last_reading = (readings + 20'h00001) >= sweep_point_total;

    // byte-lane write helper
    function [31:0] merge;
        input [31:0] old;
        input [31:0] din;
        input [3:0]  strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i]) merge[i*8 +: 8] = din[i*8 +: 8];
        end
    endfunction

    reg [31:0] wmode;
    reg [31:0] wburst;
    reg [31:0] wpts;
    reg [31:0] wdly;
    reg [31:0] wlev;

    // merged views of each writable register except the control register
    always @* begin
        wmode  = merge({23'h0, win_enter, burst_inf, prearm, edge_b, edge_a,
                        src_b, src_a}, s_axi_wdata, s_axi_wstrb);
        wburst = merge({16'h0, burst_total}, s_axi_wdata, s_axi_wstrb);
        wpts   = merge({12'h0, sweep_point_total}, s_axi_wdata, s_axi_wstrb);
        wdly   = merge({12'h0, arm_delay}, s_axi_wdata, s_axi_wstrb);
        wlev   = merge({window_upper_level, window_lower_level}, s_axi_wdata,
                       s_axi_wstrb);
    end

    // write channel; config only changes while idle, never on abort
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready      <= 1'b0;
            s_axi_wready       <= 1'b0;
            s_axi_bvalid       <= 1'b0;
            s_axi_bresp        <= 2'h0;
            cmd_begin          <= 1'b0;
            cmd_abort          <= 1'b0;
            cmd_arm_now        <= 1'b0;
            src_a              <= `SRC_HOLD;
            src_b              <= `SRC_HOLD;
            edge_a             <= 1'b0;
            edge_b             <= 1'b0;
            prearm             <= 1'b0;
            burst_inf          <= 1'b0;
            win_enter          <= 1'b0;
            burst_total        <= `RST_BURST;
            sweep_point_total  <= `RST_POINTS;
            arm_delay          <= `RST_DELAY;
            window_upper_level <= 16'h0000;
            window_lower_level <= 16'h0000;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready  <= wr_go;
            cmd_begin     <= 1'b0;
            cmd_abort     <= 1'b0;
            cmd_arm_now   <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'h0;
                case (s_axi_awaddr)
                    `OFS_CTRL: begin
                        if (s_axi_wstrb[0]) begin
                            cmd_begin   <= s_axi_wdata[`CTRL_BEGIN];
                            cmd_abort   <= s_axi_wdata[`CTRL_ABORT];
                            cmd_arm_now <= s_axi_wdata[`CTRL_ARM_NOW];
                        end
                    end
                    `OFS_MODE: begin
                        if (state == ST_IDLE) begin
                            src_a     <= wmode[`MODE_SRC_A_LO +: 2];
                            src_b     <= wmode[`MODE_SRC_B_LO +: 2];
                            edge_a    <= wmode[`MODE_EDGE_A];
                            edge_b    <= wmode[`MODE_EDGE_B];
                            prearm    <= wmode[`MODE_PREARM];
                            burst_inf <= wmode[`MODE_INF];
                            win_enter <= wmode[`MODE_WIN_ENTER];
                        end else
                            s_axi_bresp <= 2'h2;
                    end
                    `OFS_BURST:
                        if (state == ST_IDLE) burst_total <= wburst[15:0];
                        else s_axi_bresp <= 2'h2;
                    `OFS_POINTS:
                        if (state == ST_IDLE) sweep_point_total <= wpts[19:0];
                        else s_axi_bresp <= 2'h2;
                    `OFS_DELAY:
                        if (state == ST_IDLE) arm_delay <= wdly[19:0];
                        else s_axi_bresp <= 2'h2;
                    `OFS_LEVELS: begin
                        if (state == ST_IDLE) begin
                            window_upper_level <= wlev[31:16];
                            window_lower_level <= wlev[15:0];
                        end else
                            s_axi_bresp <= 2'h2;
                    end
                    `OFS_STATUS, `OFS_COUNTS: s_axi_bresp <= 2'h2;
                    default: s_axi_bresp <= 2'h3;
                endcase
            end
        end
    end

    // read channel; counts register shows readings kept
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= rd_go;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case (s_axi_araddr)
                    `OFS_CTRL:   s_axi_rdata <= 32'h00000000;
                    `OFS_MODE:   s_axi_rdata <= wmode & 32'h000001FF;
                    `OFS_BURST:  s_axi_rdata <= {16'h0000, burst_total};
                    `OFS_POINTS: s_axi_rdata <= {12'h000, sweep_point_total};
                    `OFS_DELAY:  s_axi_rdata <= {12'h000, arm_delay};
                    `OFS_LEVELS: s_axi_rdata <= {window_upper_level,
                                                 window_lower_level};
                    `OFS_STATUS: s_axi_rdata <= {11'h000, pending_op, state,
                                                 bursts_done};
                    `OFS_COUNTS: s_axi_rdata <= {12'h000,
                        (wrapped || readings >= sweep_point_total) ?
                        sweep_point_total : readings};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'h3;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    // next state; abort outranks any same-cycle event
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (cmd_begin) next_state = ST_INIT;
            ST_INIT:
                if (burst_met) next_state = ST_IDLE;
                else if (prearm) next_state = ST_WTRG;
                else next_state = ST_WARM;
            ST_WARM:
                if (delaying && delay_cnt == 20'h00000)
                    next_state = ST_WTRG;
            ST_WTRG:
                if (trig_ev && last_reading)
                    next_state = ST_INIT;
            default: next_state = ST_IDLE;
        endcase
        if (cmd_abort) next_state = ST_IDLE;
    end

    // state, counters, partition addressing
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state          <= ST_IDLE;
            bursts_done    <= 16'h0000;
            readings       <= 20'h00000;
            delay_cnt      <= 20'h00000;
            delaying       <= 1'b0;
            wrapped        <= 1'b0;
            part_base      <= 19'h00000;
            sampling       <= 1'b0;
            take_reading   <= 1'b0;
            mem_addr       <= 19'h00000;
            transfer_abort <= 1'b0;
            pending_op     <= 1'b0;
        end else begin
            state          <= next_state;
            take_reading   <= 1'b0;
            transfer_abort <= cmd_abort;
            sampling       <= (next_state == ST_WARM && prearm) ||
                              next_state == ST_WTRG;
            if (next_state == ST_IDLE) begin
                pending_op <= 1'b0;
                delaying   <= 1'b0;
            end
            case (state)
                ST_IDLE: if (cmd_begin && !cmd_abort) begin
                    pending_op  <= 1'b1;
                    bursts_done <= 16'h0000;
                    readings    <= 20'h00000;
                    wrapped     <= 1'b0;
                    part_base   <= 19'h00000;
                end
                ST_INIT: begin
                    // keep the last burst's count readable once the run is over
                    if (next_state != ST_IDLE) begin
                        readings <= 20'h00000;
                        wrapped  <= 1'b0;
                    end
                    mem_addr <= part_base;
                end
                ST_WARM: begin
                    // arm starts the delay; the arm-now command skips it
                    if (!delaying && arm_any && !cmd_abort) begin
                        delaying  <= 1'b1;
                        delay_cnt <= (cmd_arm_now || prearm) ? 20'h00000 : arm_delay;
                    end else if (delaying && delay_cnt != 20'h00000)
                        delay_cnt <= delay_cnt - 20'h00001;
                    else if (delaying)
                        delaying <= 1'b0;
                end
                ST_WTRG: if (trig_ev && !cmd_abort) begin
                    take_reading <= 1'b1;
                    // circular inside one partition
                    if (readings + 20'h00001 >= sweep_point_total) begin
                        mem_addr <= part_base;
                        wrapped  <= 1'b1;
                    end else
                        mem_addr <= mem_addr + 19'h00001;
                    readings <= readings + 20'h00001;
                    if (last_reading) begin
                        bursts_done <= bursts_done + 16'h0001;
                        part_base   <= part_base + sweep_point_total[18:0];
                    end
                end
                default: ;
            endcase
        end
    end

endmodule // arm_trigger_sequencer

/* File: verification/arm_seq_asserts.sv */
// Purpose: port-level checks on the acquisition sequencer
// Assumes: one clock domain, reset active low
// Notes: bound to every instance of the sequencer
`timescale 1ns/1ps
module arm_seq_asserts (
    input wire        clk_sys,
    input wire        arst_n,
    input wire        s_axi_awvalid,
    input wire        s_axi_wvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        sampling,
    input wire        take_reading,
    input wire        transfer_abort,
    input wire        pending_op
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // a write is offered, then answered one edge later
    sequence s_wr_req;
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    endsequence
    sequence s_wr_ans;
        s_axi_awready && s_axi_wready && s_axi_bvalid;
    endsequence
    chk_write_ans: assert property (s_wr_req |=> s_wr_ans)
        else $error("write not answered in one cycle");
    chk_ready_pair: assert property (s_axi_awready == s_axi_wready)
        else $error("address and data ready differ");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_read_ans: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=> s_axi_arready && s_axi_rvalid)
        else $error("read not answered in one cycle");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_read_pulse: assert property (take_reading |=> !take_reading)
        else $error("reading pulse longer than one cycle");
    chk_read_samp: assert property (take_reading |-> $past(sampling))
        else $error("reading taken while not sampling");
    chk_abort_idle: assert property (transfer_abort |-> !pending_op && !sampling)
        else $error("abort pulse outside idle");
    chk_idle_quiet: assert property (!pending_op |-> !sampling)
        else $error("sampling while idle");
endmodule // arm_seq_asserts

bind arm_trigger_sequencer arm_seq_asserts chk_i (.*);

/* File: verification/arm_event_source.sv */
// Purpose: external arm pins and trigger pin of the far side
// Assumes: pins are slow against the two-flop synchronisers
// Notes: pulses are long enough to survive synchronisation
`timescale 1ns/1ps
module arm_event_source (
    input  wire  clk_sys,
    output logic ext_arm_a,
    output logic ext_arm_b,
    output logic trigger_in
);
    initial {ext_arm_a, ext_arm_b, trigger_in} = 3'h0;
    // each trigger is a rise held three cycles, then three low
    task automatic trig(input int n);
        repeat (n) begin
            @(posedge clk_sys) trigger_in <= 1'b1;
            repeat (3) @(posedge clk_sys);
            trigger_in <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
    endtask
    // one arm pulse, rise and fall, so either edge selection sees it
    task automatic arm(input bit b);
        @(posedge clk_sys);
        if (b) ext_arm_b <= 1'b1;
        else ext_arm_a <= 1'b1;
        repeat (4) @(posedge clk_sys);
        {ext_arm_a, ext_arm_b} <= 2'h0;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule // arm_event_source

/* File: verification/arm_trigger_sequencer_bench.sv */
// Purpose: self-checking bench for the acquisition sequencer
// Assumes: registers reached over axi4-lite, events from arm_event_source
// Notes: status is polled, so state checks are bounded reads, not fixed waits
`timescale 1ns/1ps
`include "arm_seq_regs.vh"
module arm_trigger_sequencer_bench;
    logic        clk_sys = 0, arst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hF, stb = 4'hF, k;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [15:0] sample_a = 0, sample_b = 0, u;
    logic [18:0] mem_addr;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        ext_arm_a, ext_arm_b, trigger_in, sampling, take_reading;
    logic        transfer_abort, pending_op;
    integer      fails = 0, tests_run = 0, seen = 0, m_seen = 0, seed = 27474, n, ab = 0;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (take_reading === 1'b1) seen <= seen + 1;
    // every abort must show one transfer-stop pulse
    always @(posedge clk_sys) if (transfer_abort === 1'b1) ab <= ab + 1;
    arm_trigger_sequencer uut (.*);
    arm_event_source src (.*);
    // --------
    // bus tasks
    // --------
    task chk(input [31:0] got, input [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // address and data offered together, each dropped when taken
    task wr(input [4:0] a, input [31:0] v);
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, stb};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        forever begin
            @(posedge clk_sys);
            if (s_axi_awready) {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask
    task rd(input [4:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        forever begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                {d, r} = {s_axi_rdata, s_axi_rresp};
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask
    // bounded poll of the one-hot state field
    task st(input [3:0] s);
        for (int i = 0; i < 40; i++) begin
            rd(`OFS_STATUS);
            if (d[19:16] === s) break;
        end
        chk({28'h0, d[19:16]}, {28'h0, s});
    endtask
    task go(input [31:0] mode, input [31:0] burst, input [31:0] pts);
        wr(`OFS_MODE, mode);
        wr(`OFS_BURST, burst);
        wr(`OFS_POINTS, pts);
        wr(`OFS_CTRL, 32'h1);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard: about 50k cycles, well above the expected run
    initial begin
        #500000;
        fails++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        sample_b <= $random(seed);
        rd(`OFS_BURST); chk(d, 32'h1);
        rd(`OFS_DELAY); chk(d, 32'h0);
        st(4'h1);
        chk({31'h0, pending_op}, 32'h0);
        wr(`OFS_STATUS, 32'h0); chk({30'h0, r}, 32'h2);
        // two post-arm bursts of three readings, source b held
        go(32'h1, 32'h2, 32'h3); st(4'h4);
        src.arm(1); st(4'h4);
        wr(`OFS_BURST, 32'h5); chk({30'h0, r}, 32'h2);
        for (n = 0; n < 2; n++) begin
            src.arm(0); st(4'h8);
            src.trig(3);
            m_seen += 3;
            st(n ? 4'h1 : 4'h4);
        end
        rd(`OFS_BURST); chk(d, 32'h2);
        rd(`OFS_COUNTS); chk(d, 32'h3);
        chk(seen, m_seen);
        // falling edge on source b, abort part way through the burst
        n = 1 + ($unsigned($random(seed)) % 3);
        wr(`OFS_DELAY, 32'h40);
        go(32'h24, 32'h1, 32'h4); st(4'h4);
        src.arm(1); rd(`OFS_STATUS); chk({28'h0, d[19:16]}, 32'h4);
        st(4'h8);
        src.trig(n);
        m_seen += n;
        wr(`OFS_CTRL, 32'h2); st(4'h1);
        rd(`OFS_COUNTS); chk(d, n);
        chk(seen, m_seen);
        // pre-arm with endless burst count only stops on abort
        go(32'hC0, 32'h1, 32'h4); st(4'h8);
        src.trig(6);
        rd(`OFS_STATUS); chk({31'h0, d[20]}, 32'h1);
        wr(`OFS_CTRL, 32'h2); st(4'h1);
        chk({31'h0, pending_op}, 32'h0);
        // pre-arm count clamps at 128 bursts; partitions one point apart
        go(32'h40, 32'h81, 32'h1); st(4'h8);
        src.trig(128);
        st(4'h1); chk({16'h0, d[15:0]}, 32'h80);
        chk(mem_addr, 32'h80);
        // arm-now with both sources held skips the 64-cycle delay
        go(32'h0, 32'h1, 32'h1); st(4'h4);
        wr(`OFS_CTRL, 32'h4); rd(`OFS_STATUS); chk({28'h0, d[19:16]}, 32'h8);
        src.trig(1); st(4'h1);
        // byte strobes pick which lanes of a write land
        k = $random(seed); stb = k;
        wr(`OFS_LEVELS, 32'hFFFFFFFF); stb = 4'hF;
        rd(`OFS_LEVELS); chk(d, {{8{k[3]}}, {8{k[2]}}, {8{k[1]}}, {8{k[0]}}});
        // level-qualified arm: sample rises up to the upper level
        u = ($random(seed) & 16'h3FFF) | 16'h0010;
        wr(`OFS_LEVELS, {u, 16'h0});
        go(32'h2, 32'h1, 32'h1); st(4'h4);
        sample_a <= u;
        st(4'h8);
        n = seen;
        src.trig(1); st(4'h1);
        chk(seen - n, 32'h1);
        chk(ab, 32'h2);
        summarize();
    end
endmodule // arm_trigger_sequencer_bench
